// file: level_switch_pkg.sv
// Shared constants and types of the level switch setup controller
package level_switch_pkg;
  // Clock and time base
  localparam int CLK_NS = 5;
  localparam int TICK_NS = 10_000_000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int TW = 9;
  // Durations in milliseconds, as intended
  localparam int DEB_MS = 50;
  localparam int BRIEF_MS = 250;
  localparam int QUICK_MS = 100;
  localparam int PAUSE_MS = 2000;
  localparam int PWR_ON_MS = 1000;
  localparam int PWR_OFF_MS = 2000;
  localparam int HOLD_MS = 2000;
  localparam int RELEASE_MS = 3000;
  localparam int SLOW_MS = 500;
  localparam int FAST_MS = 100;
  // Same durations in ticks; dividing by the tick length in ms keeps every term inside 32-bit int range
  localparam int TICK_MS = TICK_NS / 1_000_000;
  localparam logic [TW-1:0] DEB_TK = TW'(DEB_MS / TICK_MS);
  localparam logic [TW-1:0] BRIEF_TK = TW'(BRIEF_MS / TICK_MS);
  localparam logic [TW-1:0] QUICK_TK = TW'(QUICK_MS / TICK_MS);
  localparam logic [TW-1:0] PAUSE_TK = TW'(PAUSE_MS / TICK_MS);
  localparam logic [TW-1:0] PWR_ON_TK = TW'(PWR_ON_MS / TICK_MS);
  localparam logic [TW-1:0] PWR_OFF_TK = TW'(PWR_OFF_MS / TICK_MS);
  localparam logic [TW-1:0] HOLD_TK = TW'(HOLD_MS / TICK_MS);
  localparam logic [TW-1:0] RELEASE_TK = TW'(RELEASE_MS / TICK_MS);
  localparam logic [TW-1:0] SLOW_TK = TW'(SLOW_MS / TICK_MS);
  localparam logic [TW-1:0] FAST_TK = TW'(FAST_MS / TICK_MS);
  // Settings defaults and hysteresis bands in level units
  localparam logic [1:0] HYST_DEF = 2'h2;
  localparam logic LED_DEF = 1'b0;
  localparam logic [7:0] THR_DEF = 8'h80;
  localparam logic [7:0] BAND_L1 = 8'h02;
  localparam logic [7:0] BAND_L2 = 8'h04;
  localparam logic [7:0] BAND_L3 = 8'h06;
  localparam logic [1:0] CONFIRM_N = 2'h3;
  // Retained settings: threshold, hysteresis level 1..3, LED option (0 = output, 1 = wetness)
  typedef struct packed {
    logic [7:0] thr;
    logic [1:0] hyst;
    logic ledMode;
  } settings_t;
  typedef enum logic [2:0] {BOOT, PWRCHK, RUN, MENU, INTRO, WAITTAP, SUB, CONFIRM} state_t;
endpackage

// file: level_switch_setup_menu.sv
// Setup menu, test function and LED indication of a vibrating-fork level switch
// Contract
// [R1] Switchpoint option entry: one brief LED blank, then LED lit two seconds.
// [R2] In switchpoint calibration, a brief activation captures present fork level as threshold.
// [R3] Successful capture is confirmed by three quick LED flashes.
// [R4] Successful capture restores hysteresis and LED option to defaults.
// [R5] After capture the device returns to the calibration main menu.
// [R6] Hysteresis entry: two blanks, two seconds lit; brief activation enters submenu.
// [R7] Hysteresis submenu cycles levels 1..3, n brief flashes then two seconds off.
// [R8] Hysteresis level two is the default.
// [R9] Activation after a level's flash group selects it, confirms, returns to menu.
// [R10] LED option entry: three blanks, two seconds lit; absent on two-wire variant.
// [R11] LED submenu cycles option one (output) and two (wetness), flashes then pause.
// [R12] Selecting an LED option gives three quick flashes then returns to menu.
// [R13] Calibration mode is left only by removing supply; no menu exit.
// [R14] Magnet held two seconds in operation forces output off and blinks LED.
// [R15] Three seconds after magnet removal the output returns to its prior state.
// [R16] Overload cuts off the load and shows fast LED blinking.
// [R17] Wiring input selects closed (active uncovered) or open (active covered) function.
// [R18] Main menu cycles options, n brief flashes then two seconds off.
// [R19] Magnet at power-up: LED on at one second, off at two; release enters menu.
// [R20] In operation LED flashes once per second when output off, steady when on.
// [R21] Activation after an option's flash group enters that option.
// [R22] Magnet input is debounced; brief activation is a stable press under two seconds.
// [R23] Threshold, hysteresis and LED option are retained in nonvolatile storage.
// [R24] All flash, pause and hold durations derive from one timer on the system clock.
`timescale 1ns/10ps
module level_switch_setup_menu
  import level_switch_pkg::*;
#(
  parameter int TickCycles = level_switch_pkg::TICK_CYC
) (
  input wire logic clk, // System clock, 200 MHz
  input wire logic rstn, // Power-on reset, active low
  input wire logic magnetIn, // Magnet sensor, high while magnet present
  input wire logic [7:0] forkLevel, // Fork immersion measure, higher is more covered
  input wire logic overloadIn, // Thermal or current overload, high while tripped
  input wire logic closedSel, // Wiring selection, high for normally-closed function
  input wire logic ledOptEn, // High where the LED option exists in the menu
  input wire level_switch_pkg::settings_t nvIn, // Settings read from nonvolatile storage
  output logic ledOut, // Status LED, high lit
  output logic switchOut, // Switching output, high active
  output logic loadCut, // Load cut off by protection
  output logic calMode, // Calibration mode active
  output logic nvStore, // One-cycle pulse: write setOut to nonvolatile storage
  output level_switch_pkg::settings_t setOut // Settings in use
);
  import level_switch_pkg::*;

  if (TickCycles < 2) begin : g_chk
    $error("TickCycles must be at least 2");
  end

  localparam int CW = $clog2(TickCycles);

  logic [CW-1:0] preCnt_r;
  logic tick_r;
  logic magDeb_r;
  logic [TW-1:0] debCnt_r;
  logic [TW-1:0] holdCnt_r;
  logic tap_r;
  logic testOn_r;
  logic [TW-1:0] relCnt_r;
  logic [TW-1:0] slowCnt_r;
  logic [TW-1:0] fastCnt_r;
  logic slowPh_r;
  logic fastPh_r;
  logic wet_r;
  state_t st_r;
  logic [1:0] opt_r;
  logic [1:0] sub_r;
  logic [2:0] slot_r;
  logic [TW-1:0] tcnt_r;
  logic [TW-1:0] pwrCnt_r;
  settings_t set_r;
  logic nvStore_r;
  logic ledOut_r;
  logic switchOut_r;
  logic loadCut_r;
  logic calMode_r;

  logic [1:0] grpN;
  logic [2:0] grpSlots;
  logic [TW-1:0] slotLen;
  logic slotEnd;
  logic lastSlot;
  logic inPause;
  logic flashOn;
  logic [1:0] optMax;
  logic [1:0] subMax;
  logic outAct;
  logic [7:0] band;
  logic [7:0] relThr;

  // Time base: one tick every TickCycles clocks
  always_ff @(posedge clk or negedge rstn) begin // [R24]
    if (!rstn) begin
      preCnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (preCnt_r == CW'(TickCycles - 1));
      preCnt_r <= (preCnt_r == CW'(TickCycles - 1)) ? '0 : preCnt_r + 1'b1;
    end
  end

  // Magnet debounce, hold length and brief-activation pulse on release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      magDeb_r <= 1'b0;
      debCnt_r <= '0;
      holdCnt_r <= '0;
      tap_r <= 1'b0;
    end else begin
      tap_r <= 1'b0;
      if (magnetIn == magDeb_r) begin
        debCnt_r <= '0;
      end else if (tick_r) begin
        if (debCnt_r >= DEB_TK - 1'b1) begin // [R22]
          magDeb_r <= magnetIn;
          debCnt_r <= '0;
          tap_r <= magDeb_r && (holdCnt_r < HOLD_TK); // [R22]
        end else begin
          debCnt_r <= debCnt_r + 1'b1;
        end
      end
      if (!magDeb_r) begin
        holdCnt_r <= '0;
      end else if (tick_r && holdCnt_r < HOLD_TK) begin
        holdCnt_r <= holdCnt_r + 1'b1;
      end
    end
  end

  // Output test: long hold forces output off, release delay restores it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      testOn_r <= 1'b0;
      relCnt_r <= '0;
    end else if (st_r != RUN) begin
      testOn_r <= 1'b0;
      relCnt_r <= '0;
    end else if (magDeb_r) begin
      relCnt_r <= '0;
      if (holdCnt_r >= HOLD_TK) begin
        testOn_r <= 1'b1; // [R14]
      end
    end else if (testOn_r && tick_r) begin
      if (relCnt_r >= RELEASE_TK - 1'b1) begin
        testOn_r <= 1'b0; // [R15]
        relCnt_r <= '0;
      end else begin
        relCnt_r <= relCnt_r + 1'b1;
      end
    end
  end

  // Slow and fast blink phases
  always_ff @(posedge clk or negedge rstn) begin // [R24]
    if (!rstn) begin
      slowCnt_r <= '0;
      fastCnt_r <= '0;
      slowPh_r <= 1'b0;
      fastPh_r <= 1'b0;
    end else if (tick_r) begin
      slowCnt_r <= (slowCnt_r >= SLOW_TK - 1'b1) ? '0 : slowCnt_r + 1'b1;
      fastCnt_r <= (fastCnt_r >= FAST_TK - 1'b1) ? '0 : fastCnt_r + 1'b1;
      if (slowCnt_r >= SLOW_TK - 1'b1) begin
        slowPh_r <= ~slowPh_r;
      end
      if (fastCnt_r >= FAST_TK - 1'b1) begin
        fastPh_r <= ~fastPh_r;
      end
    end
  end

  // Wetness from threshold with selected hysteresis band
  always_comb begin
    unique case (set_r.hyst)
      2'h1: band = BAND_L1;
      2'h3: band = BAND_L3;
      default: band = BAND_L2;
    endcase
    relThr = (set_r.thr > band) ? set_r.thr - band : 8'h00;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wet_r <= 1'b0;
    end else if (forkLevel >= set_r.thr) begin
      wet_r <= 1'b1;
    end else if (forkLevel < relThr) begin
      wet_r <= 1'b0;
    end
  end

  // Flash group sequencer: 2n brief slots alternating on/off, then a pause slot (quick slots and no pause slot in CONFIRM)
  always_comb begin
    unique case (st_r)
      MENU, INTRO: grpN = opt_r;
      SUB: grpN = sub_r;
      default: grpN = CONFIRM_N;
    endcase
    grpSlots = {grpN, 1'b0};
    inPause = (slot_r == grpSlots);
    slotLen = (st_r == CONFIRM) ? QUICK_TK : (inPause ? PAUSE_TK : BRIEF_TK); // [R24]
    slotEnd = tick_r && (tcnt_r >= slotLen - 1'b1);
    lastSlot = (st_r == CONFIRM) ? (slot_r == grpSlots - 3'h1) : inPause;
    flashOn = (slot_r < grpSlots) && !slot_r[0];
    optMax = ledOptEn ? 2'h3 : 2'h2; // [R10]
    subMax = (opt_r == 2'h2) ? 2'h3 : 2'h2;
    outAct = closedSel ? !wet_r : wet_r; // [R17]
  end

  // Menu state machine; calibration only ends with a reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= BOOT;
      opt_r <= 2'h1;
      sub_r <= 2'h1;
      slot_r <= '0;
      tcnt_r <= '0;
      pwrCnt_r <= '0;
      set_r <= '{thr: THR_DEF, hyst: HYST_DEF, ledMode: LED_DEF};
      nvStore_r <= 1'b0;
    end else begin
      nvStore_r <= 1'b0;
      if (slotEnd) begin
        tcnt_r <= '0;
        slot_r <= lastSlot ? 3'h0 : slot_r + 3'h1;
      end else if (tick_r) begin
        tcnt_r <= tcnt_r + 1'b1;
      end
      unique case (st_r)
        BOOT: begin
          set_r <= nvIn; // [R23]
          st_r <= magnetIn ? PWRCHK : RUN;
        end
        PWRCHK: begin
          if (tick_r && pwrCnt_r < PWR_OFF_TK) begin
            pwrCnt_r <= pwrCnt_r + 1'b1;
          end
          // Raw level too: the debounced level is still low for the first ticks after power-up
          if (!magnetIn && !magDeb_r) begin
            st_r <= (pwrCnt_r >= PWR_OFF_TK) ? MENU : RUN; // [R19]
            slot_r <= '0;
            tcnt_r <= '0;
          end
        end
        RUN: st_r <= RUN;
        MENU: begin
          if (tap_r && inPause) begin
            st_r <= INTRO; // [R21]
            slot_r <= '0;
            tcnt_r <= '0;
          end else if (slotEnd && lastSlot) begin
            opt_r <= (opt_r >= optMax) ? 2'h1 : opt_r + 2'h1; // [R18]
          end
        end
        INTRO: begin
          if (slotEnd && lastSlot) begin
            st_r <= WAITTAP; // [R1] [R6] [R10]
          end
        end
        WAITTAP: begin
          if (tap_r) begin
            slot_r <= '0;
            tcnt_r <= '0;
            if (opt_r == 2'h1) begin
              set_r <= '{thr: forkLevel, hyst: HYST_DEF, ledMode: LED_DEF}; // [R2] [R4] [R8]
              nvStore_r <= 1'b1; // [R23]
              st_r <= CONFIRM;
            end else begin
              sub_r <= 2'h1;
              st_r <= SUB; // [R6] [R10]
            end
          end
        end
        SUB: begin
          if (tap_r && inPause) begin
            if (opt_r == 2'h2) begin
              set_r.hyst <= sub_r; // [R9]
            end else begin
              set_r.ledMode <= (sub_r == 2'h2); // [R11]
            end
            nvStore_r <= 1'b1; // [R23]
            st_r <= CONFIRM;
            slot_r <= '0;
            tcnt_r <= '0;
          end else if (slotEnd && lastSlot) begin
            sub_r <= (sub_r >= subMax) ? 2'h1 : sub_r + 2'h1; // [R7] [R11]
          end
        end
        CONFIRM: begin
          if (slotEnd && lastSlot) begin
            st_r <= MENU; // [R5] [R9] [R12] [R13]
            opt_r <= 2'h1;
          end
        end
      endcase
    end
  end

  // LED, output and status registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ledOut_r <= 1'b0;
      switchOut_r <= 1'b0;
      loadCut_r <= 1'b0;
      calMode_r <= 1'b0;
    end else begin
      loadCut_r <= overloadIn; // [R16]
      calMode_r <= (st_r != RUN) && (st_r != BOOT) && (st_r != PWRCHK); // [R13]
      switchOut_r <= (st_r == RUN) && outAct && !testOn_r && !overloadIn; // [R14] [R15] [R16] [R17]
      unique case (st_r)
        PWRCHK: ledOut_r <= (pwrCnt_r >= PWR_ON_TK) && (pwrCnt_r < PWR_OFF_TK); // [R19]
        MENU, SUB, CONFIRM: ledOut_r <= flashOn; // [R3] [R7] [R12] [R18]
        INTRO: ledOut_r <= !flashOn; // [R1] [R6] [R10]
        RUN: begin
          if (overloadIn || testOn_r) begin
            ledOut_r <= fastPh_r; // [R14] [R16]
          end else begin
            ledOut_r <= (set_r.ledMode ? wet_r : outAct) || slowPh_r; // [R20] [R11]
          end
        end
        default: ledOut_r <= 1'b0;
      endcase
    end
  end

  assign ledOut = ledOut_r;
  assign switchOut = switchOut_r;
  assign loadCut = loadCut_r;
  assign calMode = calMode_r;
  assign nvStore = nvStore_r;
  assign setOut = set_r;
endmodule

// file: level_switch_setup_menu_props.sv
// Port assertions of the setup controller
`timescale 1ns/10ps
module level_switch_setup_menu_props
  import level_switch_pkg::*;
#(
  parameter int TickCycles = 10
) (
  input wire logic clk, // Clock
  input wire logic rstn, // Reset, active low
  input wire logic magnetIn, // Magnet sensor
  input wire logic [7:0] forkLevel, // Fork measure
  input wire logic overloadIn, // Overload trip
  input wire logic closedSel, // Function select
  input wire logic ledOptEn, // LED option present
  input wire level_switch_pkg::settings_t nvIn, // Stored settings
  input wire logic ledOut, // LED
  input wire logic switchOut, // Output
  input wire logic loadCut, // Load cut
  input wire logic calMode, // Calibration mode
  input wire logic nvStore, // Store pulse
  input wire level_switch_pkg::settings_t setOut // Settings in use
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Overload, calibration and storage relations
  property p_cutOn; overloadIn |=> loadCut; endproperty
  a_cutOn: assert property (p_cutOn) else $error("load not cut");
  property p_cutOff; !overloadIn |=> !loadCut; endproperty
  a_cutOff: assert property (p_cutOff) else $error("load cut without overload");
  property p_loadOff; overloadIn |=> !switchOut; endproperty
  a_loadOff: assert property (p_loadOff) else $error("output on under overload");
  property p_calOut; calMode |-> !switchOut; endproperty
  a_calOut: assert property (p_calOut) else $error("output on in calibration");
  property p_calStay; calMode |=> calMode; endproperty
  a_calStay: assert property (p_calStay) else $error("calibration left");
  property p_storePulse; nvStore |=> !nvStore; endproperty
  a_storePulse: assert property (p_storePulse) else $error("store pulse too long");
  property p_storeCal; nvStore |-> calMode; endproperty
  a_storeCal: assert property (p_storeCal) else $error("store outside calibration");
  property p_setHold; !nvStore && $past(calMode) |-> $stable(setOut); endproperty
  a_setHold: assert property (p_setHold) else $error("settings changed without store");
  property p_tapRel; nvStore |-> !$past(magnetIn, 8); endproperty
  a_tapRel: assert property (p_tapRel) else $error("store before debounced release");
  c_store: cover property (nvStore);
  c_cal: cover property ($rose(calMode));
  c_trip: cover property (overloadIn ##1 loadCut);
  c_test: cover property ($fell(switchOut) && !overloadIn && !calMode);
endmodule
bind level_switch_setup_menu level_switch_setup_menu_props #(.TickCycles(TickCycles)) props (.clk(clk),
  .rstn(rstn), .magnetIn(magnetIn), .forkLevel(forkLevel), .overloadIn(overloadIn), .closedSel(closedSel),
  .ledOptEn(ledOptEn), .nvIn(nvIn), .ledOut(ledOut), .switchOut(switchOut), .loadCut(loadCut),
  .calMode(calMode), .nvStore(nvStore), .setOut(setOut));

// file: magnet_operator.sv
// Operator who places and removes the test magnet
`timescale 1ns/10ps
module magnet_operator (
  input wire logic clk, // System clock
  output logic magnetIn // High while the magnet is placed
);
  initial magnetIn = 1'b0;
  // Place or remove the magnet just after an edge
  task automatic put(input logic v);
    @(posedge clk);
    #1 magnetIn = v;
  endtask
  // Brief placement, well under the hold time
  task automatic tap();
    put(1'b1);
    repeat (100) @(posedge clk);
    put(1'b0);
  endtask
endmodule

// file: testbench.sv
// Self-checking bench of the setup controller
`timescale 1ns/10ps
module testbench;
  import level_switch_pkg::*;
  logic clk, rstn, magnetIn, overloadIn, closedSel, ledOptEn;
  logic ledOut, switchOut, loadCut, calMode, nvStore;
  logic [7:0] forkLevel;
  settings_t nvIn, setOut;
  int errors, compares;
  // Controller with a short time base
  level_switch_setup_menu #(.TickCycles(10)) DUT (.clk(clk), .rstn(rstn), .magnetIn(magnetIn),
    .forkLevel(forkLevel), .overloadIn(overloadIn), .closedSel(closedSel), .ledOptEn(ledOptEn), .nvIn(nvIn),
    .ledOut(ledOut), .switchOut(switchOut), .loadCut(loadCut), .calMode(calMode), .nvStore(nvStore),
    .setOut(setOut));
  magnet_operator OP (.clk(clk), .magnetIn(magnetIn));
  // Clock
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic final_report();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Count LED turn-ons until the window ends or the LED stays lit hi cycles
  task automatic rises(input int win, input int hi, output int n);
    logic prev;
    int run;
    prev = ledOut;
    n = 0;
    run = 0;
    repeat (win) begin
      cyc(1);
      if (ledOut && !prev) n++;
      run = ledOut ? run + 1 : 0;
      prev = ledOut;
      if (run == hi) break;
    end
  endtask
  // Wait until flash group n has ended and its pause is running
  task automatic seek(input int n);
    logic prev;
    int cnt, low, armed;
    prev = ledOut;
    cnt = 0;
    low = 0;
    armed = 0;
    repeat (30000) begin
      cyc(1);
      if (ledOut && !prev) cnt++;
      low = ledOut ? 0 : low + 1;
      prev = ledOut;
      if (low == 400) begin
        if (armed && cnt == n) return;
        armed = 1;
        cnt = 0;
      end
    end
    check(1'b0, "flash group not found");
  endtask
  // Enter an option and wait for the lit phase to end
  task automatic enter(input int n);
    int k;
    OP.tap();
    rises(5000, 1500, k);
    check(k == n, "entry blank count");
    repeat (1000) begin
      cyc(1);
      if (!ledOut) break;
    end
  endtask
  // Tap that stores settings and is confirmed by three quick flashes
  task automatic pick();
    int n;
    OP.tap();
    repeat (300) begin
      cyc(1);
      if (nvStore === 1'b1) break;
    end
    check(nvStore, "no store after tap");
    rises(500, 1000, n);
    check(n == 3, "confirm flash count");
  endtask
  task automatic resetDut(input logic mag);
    rstn = 1'b0;
    OP.put(mag);
    cyc(5);
    rstn = 1'b1;
  endtask
  task automatic testRun();
    int n;
    nvIn = {8'h80, 2'h2, 1'b0};
    resetDut(1'b0);
    closedSel = 1'b1;
    forkLevel = 8'h10;
    cyc(100);
    check(setOut === nvIn, "settings not loaded");
    check(switchOut === 1'b1 && calMode === 1'b0, "closed dry");
    rises(600, 2000, n);
    check(n == 0 && ledOut === 1'b1, "steady LED");
    forkLevel = 8'h90;
    cyc(50);
    check(switchOut === 1'b0, "closed wet");
    rises(1100, 2000, n);
    check(n >= 1 && n <= 2, "slow blink");
    closedSel = 1'b0;
    forkLevel = 8'h7d;
    cyc(50);
    check(switchOut === 1'b1, "open inside band");
    forkLevel = 8'h7b;
    cyc(50);
    check(switchOut === 1'b0, "open below band");
    $display("run test done");
  endtask
  task automatic testTrip();
    int n;
    forkLevel = 8'h90;
    cyc(50);
    overloadIn = 1'b1;
    cyc(2);
    check(switchOut === 1'b0 && loadCut === 1'b1, "overload cut");
    rises(500, 2000, n);
    check(n >= 2, "overload blink");
    overloadIn = 1'b0;
    cyc(20);
    check(switchOut === 1'b1 && loadCut === 1'b0, "overload end");
    OP.put(1'b1);
    cyc(1900);
    check(switchOut === 1'b1, "test too early");
    cyc(300);
    check(switchOut === 1'b0, "test off");
    rises(500, 2000, n);
    check(n >= 2, "test blink");
    OP.put(1'b0);
    cyc(2900);
    check(switchOut === 1'b0, "restore too early");
    cyc(300);
    check(switchOut === 1'b1, "restore");
    $display("trip test done");
  endtask
  task automatic testCal();
    nvIn = {8'h80, 2'h1, 1'b1};
    resetDut(1'b1);
    cyc(1100);
    check(ledOut === 1'b1, "power-up LED on");
    cyc(1000);
    check(ledOut === 1'b0, "power-up LED off");
    OP.put(1'b0);
    forkLevel = 8'h60;
    seek(1);
    enter(1);
    pick();
    check(setOut === {8'h60, 2'h2, 1'b0}, "capture");
    seek(2);
    enter(2);
    OP.tap();
    seek(3);
    pick();
    check(setOut.hyst === 2'h3 && setOut.thr === 8'h60, "level three");
    seek(3);
    enter(3);
    OP.tap();
    seek(2);
    pick();
    check(setOut.ledMode === 1'b1, "wetness option");
    check(calMode === 1'b1 && switchOut === 1'b0, "still calibrating");
    $display("calibration test done");
  endtask
  // Two-wire variant: after option two the menu wraps to option one
  task automatic testTwoWire();
    int n;
    ledOptEn = 1'b0;
    resetDut(1'b1);
    cyc(2100);
    OP.put(1'b0);
    seek(2);
    rises(2600, 3000, n);
    check(n == 1, "third option shown on two-wire variant");
    $display("two-wire test done");
  endtask
  // Main sequence
  initial begin
    rstn = 1'b0;
    overloadIn = 1'b0;
    closedSel = 1'b0;
    ledOptEn = 1'b1;
    forkLevel = 8'h00;
    nvIn = '0;
    errors = 0;
    compares = 0;
    testRun();
    testTrip();
    testCal();
    testTwoWire();
    final_report();
  end
  // Watchdog
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report();
  end
endmodule
